// ### core/codec_regs_pkg.sv
package codec_regs_pkg;
    // ------------------------------------------------------------
    // Address space
    // ------------------------------------------------------------
    localparam int ADDR_W = 5;
    localparam int DATA_W = 8;
    localparam int NUM_REGS = 19;
    localparam logic [4:0] LAST_REG = 5'h12;
    localparam logic [4:0] RST_ADDR = 5'h00;
    localparam logic [4:0] ADC_PWR_ADDR = 5'h01;
    localparam logic [4:0] DAC_PWR_ADDR = 5'h02;
    localparam logic [4:0] FMT_ADDR = 5'h03;
    localparam logic [4:0] CLK_ADDR = 5'h04;
    localparam logic [4:0] DEEM_ADDR = 5'h05;
    localparam logic [4:0] OVF_ADDR = 5'h06;
    localparam logic [4:0] ZD_ADDR = 5'h07;
    localparam logic [4:0] ADC_DIFF_ADDR = 5'h08;
    localparam logic [4:0] DAC_DIFF_ADDR = 5'h09;
    localparam logic [4:0] ATT_BASE = 5'h0a;
    localparam int NUM_ATT = 8;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_DEF = 8'h08;
    localparam logic [7:0] ADC_PWR_DEF = 8'h03;
    localparam logic [7:0] DAC_PWR_DEF = 8'h0f;
    localparam logic [7:0] FMT_DEF = 8'h80;
    localparam logic [7:0] CLK_DEF = 8'h00;
    localparam logic [7:0] DEEM_DEF = 8'h55;
    localparam logic [7:0] OVF_DEF = 8'h07;
    localparam logic [7:0] ZD_DEF = 8'h0f;
    localparam logic [7:0] ZERO_DEF = 8'h00;
    localparam logic [7:0] ATT_DEF = 8'hff;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int TRST_BIT = 0;
    localparam int DACG_BIT = 1;
    localparam int ADCG_BIT = 2;
    localparam int VREF_BIT = 3;
    localparam int MUTE_BIT = 0;
    localparam int ATS_LSB = 1;
    localparam int TDM_LSB = 3;
    localparam int DIF_LSB = 5;
    localparam int DIV_BIT = 0;
    localparam int AUTO_CLOCK_BIT_BIT = 1;
    localparam int DFS_LSB = 2;
    localparam int CKS_LSB = 4;
    localparam int CLOCK_OUTPUT_ENABLE_BIT = 6;
    localparam int OVERFLOW_ENABLE_BIT = 3;
    localparam int LOOP_LSB = 4;

    // Loopback codes and output format remap
    localparam logic [1:0] LOOP_ADC = 2'h1;
    localparam logic [1:0] LOOP_COPY = 2'h2;
    localparam logic [2:0] FMT_M0 = 3'h0;
    localparam logic [2:0] FMT_M1 = 3'h1;
    localparam logic [2:0] FMT_M2 = 3'h2;
    localparam logic [2:0] FMT_M3 = 3'h3;
    localparam logic [2:0] FMT_M5 = 3'h5;
endpackage : codec_regs_pkg

// ### core/ctrl_reg_byte.sv
`timescale 1ns/100ps
// One control byte with synchronous restore to default
module ctrl_reg_byte
    import codec_regs_pkg::*;
#(
    parameter logic [7:0] DEF = 8'h00
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic ce,
    input wire logic clr,
    input wire logic we,
    input wire logic [7:0] wdata,
    output logic [7:0] q
);
    logic [7:0] q_ff;
    logic [7:0] nxt_q;

    // Power-down clear wins over a write
    always_comb begin
        nxt_q = q_ff;
        if (clr) begin
            nxt_q = DEF;
        end else if (we) begin
            nxt_q = wdata;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            q_ff <= DEF;
        end else if (ce) begin
            q_ff <= nxt_q;
        end
    end

    assign q = q_ff;
endmodule : ctrl_reg_byte

// ### core/mclk_out_gen.sv
`timescale 1ns/100ps
// Master clock output: full rate, half rate, or held low
module mclk_out_gen
    import codec_regs_pkg::*;
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic ce,
    input wire logic enable,
    input wire logic half_rate,
    output logic mclk_out
);
    logic div_ff;
    logic nxt_div;
    logic out_ff;
    logic nxt_out;

    // Full rate flips every cycle; half rate only when the divider is high
    always_comb begin
        nxt_div = ~div_ff;
        nxt_out = 1'b0;
        if (enable) begin
            nxt_out = (half_rate && !div_ff) ? out_ff : ~out_ff;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            div_ff <= 1'b0;
            out_ff <= 1'b0;
        end else if (ce) begin
            div_ff <= nxt_div;
            out_ff <= nxt_out;
        end
    end

    assign mclk_out = out_ff;
endmodule : mclk_out_gen

// ### core/codec_control_register_bank.sv
`timescale 1ns/100ps
module codec_control_register_bank
    import codec_regs_pkg::*;
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic ce,
    input wire logic power_down_pin_n,
    input wire logic wr_strobe,
    input wire logic [ADDR_W-1:0] wr_addr,
    input wire logic [DATA_W-1:0] wr_data,
    input wire logic [ADDR_W-1:0] rd_addr,
    output logic [DATA_W-1:0] rd_data,
    input wire logic [1:0] zero_detect_raw,
    input wire logic overflow_raw,
    output logic [1:0] zero_detect_pins,
    output logic timing_reset_n,
    output logic dac_group_power,
    output logic adc_group_power,
    output logic reference_power,
    output logic [1:0] adc_channel_power,
    output logic [3:0] dac_channel_power,
    output logic soft_mute_bit,
    output logic [1:0] attenuator_ramp_select,
    output logic [2:0] audio_format_select,
    output logic [1:0] tdm_format_select,
    output logic [2:0] adc_output_format,
    output logic auto_clock_bit,
    output logic [1:0] speed_mode_select,
    output logic speed_mode_manual,
    output logic [1:0] clock_ratio_select,
    output logic mclk_out,
    output logic [7:0] deemphasis_select,
    output logic [2:0] overflow_mode_select,
    output logic overflow_enable,
    output logic [3:0] zero_detect_mode_select,
    output logic [1:0] loopback_select,
    output logic loop_adc_to_dac,
    output logic loop_copy_input1,
    output logic [1:0] adc_differential_enable,
    output logic [3:0] dac_differential_enable,
    output logic [63:0] attenuation_level
);
    // ------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------
    localparam logic [7:0] DEFS [NUM_REGS] = '{
        RST_DEF, ADC_PWR_DEF, DAC_PWR_DEF, FMT_DEF, CLK_DEF,
        DEEM_DEF, OVF_DEF, ZD_DEF, ZERO_DEF, ZERO_DEF,
        ATT_DEF, ATT_DEF, ATT_DEF, ATT_DEF,
        ATT_DEF, ATT_DEF, ATT_DEF, ATT_DEF, ZERO_DEF
    };

    logic [7:0] regs [NUM_REGS];
    logic in_map;
    logic clr;

    // Addresses past the last register never reach storage
    assign in_map = (wr_addr <= LAST_REG);
    // Pin low restores every byte to default on cycles with ce high; an async reset is separate
    assign clr = ~power_down_pin_n;

    // One byte per address; address arrives whole, MSB first upstream
    genvar gi;
    generate
        for (gi = 0; gi < NUM_REGS; gi++) begin : g_reg
            ctrl_reg_byte #(
                .DEF(DEFS[gi])
            ) u_byte (
                .clock(clock),
                .nrst(nrst),
                .ce(ce),
                .clr(clr),
                .we(wr_strobe && in_map &&
                    (wr_addr == ADDR_W'(gi))),
                .wdata(wr_data),
                .q(regs[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Field decode
    // ------------------------------------------------------------
    logic [7:0] r_rst;
    logic [7:0] r_fmt;
    logic [7:0] r_clk;
    logic [7:0] r_ovf;
    logic [2:0] fmt;
    logic [1:0] loop;
    logic [2:0] out_fmt;

    assign r_rst = regs[RST_ADDR];
    assign r_fmt = regs[FMT_ADDR];
    assign r_clk = regs[CLK_ADDR];
    assign r_ovf = regs[OVF_ADDR];
    assign fmt = r_fmt[DIF_LSB +: 3];
    assign loop = r_ovf[LOOP_LSB +: 2];

    // ADC output format follows loopback remap
    always_comb begin
        out_fmt = fmt;
        if (loop == LOOP_ADC) begin
            if (fmt == FMT_M0 || fmt == FMT_M1) begin
                out_fmt = FMT_M3;
            end else if (fmt == FMT_M2) begin
                out_fmt = FMT_M5;
            end
        end
    end

    // ------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------
    logic [1:0] zd_ff, nxt_zd;
    logic [7:0] rd_ff, nxt_rd;
    logic [2:0] ofmt_ff, nxt_ofmt;
    logic lpa_ff, nxt_lpa;
    logic lpc_ff, nxt_lpc;
    logic man_ff, nxt_man;
    logic [1:0] dfs_ff, nxt_dfs;

    // Overflow steals pin two; timing reset forces both high
    always_comb begin
        nxt_zd = zero_detect_raw;
        if (r_ovf[OVERFLOW_ENABLE_BIT]) begin
            nxt_zd[1] = overflow_raw;
        end
        if (!r_rst[TRST_BIT]) begin
            nxt_zd = 2'h3;
        end
        nxt_rd = (rd_addr <= LAST_REG) ? regs[rd_addr] : ZERO_DEF;
        nxt_ofmt = out_fmt;
        nxt_lpa = (loop == LOOP_ADC);
        nxt_lpc = (loop == LOOP_COPY);
        // Auto mode masks the manual speed field to the core
        nxt_man = ~r_clk[AUTO_CLOCK_BIT_BIT];
        nxt_dfs = r_clk[AUTO_CLOCK_BIT_BIT] ? 2'h0 : r_clk[DFS_LSB +: 2];
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            zd_ff <= 2'h3;
            rd_ff <= ZERO_DEF;
            ofmt_ff <= FMT_DEF[DIF_LSB +: 3];
            lpa_ff <= 1'b0;
            lpc_ff <= 1'b0;
            man_ff <= 1'b1;
            dfs_ff <= 2'h0;
        end else if (ce) begin
            zd_ff <= nxt_zd;
            rd_ff <= nxt_rd;
            ofmt_ff <= nxt_ofmt;
            lpa_ff <= nxt_lpa;
            lpc_ff <= nxt_lpc;
            man_ff <= nxt_man;
            dfs_ff <= nxt_dfs;
        end
    end

    // Field outputs come straight from the byte flip-flops; derived outputs come from the registered stage above
    assign timing_reset_n = r_rst[TRST_BIT];
    assign dac_group_power = r_rst[DACG_BIT];
    assign adc_group_power = r_rst[ADCG_BIT];
    assign reference_power = r_rst[VREF_BIT]; // host's duty
    assign adc_channel_power = regs[ADC_PWR_ADDR][1:0];
    assign dac_channel_power = regs[DAC_PWR_ADDR][3:0];
    assign soft_mute_bit = r_fmt[MUTE_BIT];
    assign attenuator_ramp_select = r_fmt[ATS_LSB +: 2];
    assign audio_format_select = fmt;
    assign tdm_format_select = r_fmt[TDM_LSB +: 2];
    assign clock_ratio_select = r_clk[CKS_LSB +: 2];
    assign auto_clock_bit = r_clk[AUTO_CLOCK_BIT_BIT];
    assign deemphasis_select = regs[DEEM_ADDR];
    assign overflow_mode_select = r_ovf[2:0];
    assign overflow_enable = r_ovf[OVERFLOW_ENABLE_BIT];
    assign zero_detect_mode_select = regs[ZD_ADDR][3:0];
    assign loopback_select = loop;
    assign adc_differential_enable = regs[ADC_DIFF_ADDR][1:0];
    assign dac_differential_enable = regs[DAC_DIFF_ADDR][3:0];
    assign zero_detect_pins = zd_ff;
    assign rd_data = rd_ff;
    assign adc_output_format = ofmt_ff;
    assign loop_adc_to_dac = lpa_ff;
    assign loop_copy_input1 = lpc_ff;
    assign speed_mode_manual = man_ff;
    assign speed_mode_select = dfs_ff;

    // Eight attenuation bytes, one per DAC channel
    generate
        for (gi = 0; gi < NUM_ATT; gi++) begin : g_att
            assign attenuation_level[gi*8 +: 8] =
                regs[ATT_BASE + ADDR_W'(gi)];
        end
    endgenerate

    // ------------------------------------------------------------
    // Master clock output
    // ------------------------------------------------------------
    mclk_out_gen u_mclk (
        .clock(clock),
        .nrst(nrst),
        .ce(ce),
        .enable(r_clk[CLOCK_OUTPUT_ENABLE_BIT]),
        .half_rate(r_clk[DIV_BIT]),
        .mclk_out(mclk_out)
    );

    // is the host's duty: a repeated write is simply stored again
endmodule : codec_control_register_bank

// ### verification/codec_bank_checker.sv
`timescale 1ns/100ps
// Watches the bank's ports; one edge of the device clock
module codec_bank_checker (
    input wire logic clock,
    input wire logic nrst,
    input wire logic ce,
    input wire logic power_down_pin_n,
    input wire logic wr_strobe,
    input wire logic [4:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic timing_reset_n,
    input wire logic [1:0] zero_detect_pins,
    input wire logic overflow_raw,
    input wire logic overflow_enable,
    input wire logic soft_mute_bit,
    input wire logic auto_clock_bit,
    input wire logic [1:0] speed_mode_select,
    input wire logic [1:0] loopback_select,
    input wire logic loop_adc_to_dac,
    input wire logic loop_copy_input1,
    input wire logic [2:0] audio_format_select,
    input wire logic [63:0] attenuation_level
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);
    // Writes qualified by enable and no power-down
    logic live_wr;
    assign live_wr = ce && power_down_pin_n && wr_strobe;

    AST_POWER_DOWN_DEF: assert property (
        ce && !power_down_pin_n |=> audio_format_select == 3'h4
        && !soft_mute_bit) else $error("power-down left a field set");
    AST_TRST_PINS_HIGH: assert property (
        ce && !timing_reset_n |=> zero_detect_pins == 2'b11)
        else $error("zero-detect pins low during timing reset");
    AST_UNUSED_WRITE: assert property (
        live_wr && wr_addr > 5'h12 |=> $stable(soft_mute_bit)
        && $stable(attenuation_level)) else $error("unused write stored");
    AST_MUTE_WRITE: assert property (
        live_wr && wr_addr == 5'h03 |=> soft_mute_bit == $past(wr_data[0]))
        else $error("mute bit did not follow write");
    AST_AUTO_SPEED: assert property (
        ce && auto_clock_bit |=> speed_mode_select == 2'h0)
        else $error("speed field not ignored in auto mode");
    AST_LOOP_ADC: assert property (
        ce && power_down_pin_n && loopback_select == 2'h1
        |=> loop_adc_to_dac && !loop_copy_input1) else $error("bad loop");
    AST_LOOP_NONE: assert property (
        ce && loopback_select == 2'h3 |=> !loop_adc_to_dac
        && !loop_copy_input1) else $error("loop code 3 routed");
    AST_OVF_PIN: assert property (
        ce && power_down_pin_n && timing_reset_n && overflow_enable
        |=> zero_detect_pins[1] == $past(overflow_raw))
        else $error("shared pin not showing overflow");
    cover property (live_wr && wr_addr > 5'h12);
    cover property (loop_copy_input1);
    cover property ($fell(power_down_pin_n));
endmodule : codec_bank_checker

bind codec_control_register_bank codec_bank_checker i_chk (.*);

// ### verification/codec_host_model.sv
`timescale 1ns/100ps
// Host side of the control port; drives only on falling edges
module codec_host_model (
    input wire logic clock,
    input wire logic [7:0] rd_data,
    output logic wr_strobe,
    output logic [4:0] wr_addr,
    output logic [7:0] wr_data,
    output logic [4:0] rd_addr
);
    initial begin
        wr_strobe = 1'b0;
        wr_addr = 5'h00;
        wr_data = 8'h00;
        rd_addr = 5'h00;
    end
    // Five-bit address with one byte, held over one rising edge
    task automatic write_reg(input logic [4:0] a, input logic [7:0] d);
        @(negedge clock);
        wr_strobe = 1'b1;
        wr_addr = a;
        wr_data = d;
        @(negedge clock);
        wr_strobe = 1'b0;
        wr_addr = ~a; // Stale values must not be trusted
        wr_data = ~d;
    endtask : write_reg
    // Registered answer arrives one cycle after the address
    task automatic read_reg(input logic [4:0] a, output logic [7:0] d);
        @(negedge clock);
        rd_addr = a;
        @(negedge clock);
        d = rd_data;
    endtask : read_reg
    // Reference stays on; release rewritten after a frame gap
    task automatic power_up();
        write_reg(5'h00, 8'h0f);
        repeat (8) @(negedge clock);
        write_reg(5'h00, 8'h0f);
    endtask : power_up
endmodule : codec_host_model

// ### verification/codec_control_register_bank_tb.sv
`timescale 1ns/100ps
module codec_control_register_bank_tb;
    import codec_regs_pkg::*;
    logic clock, nrst, ce, power_down_pin_n, wr_strobe, overflow_raw;
    logic timing_reset_n, dac_group_power, adc_group_power;
    logic reference_power, soft_mute_bit, auto_clock_bit, mclk_out;
    logic speed_mode_manual, overflow_enable, loop_adc_to_dac;
    logic loop_copy_input1;
    logic [4:0] wr_addr, rd_addr;
    logic [7:0] wr_data, rd_data, deemphasis_select, v;
    logic [1:0] zero_detect_raw, zero_detect_pins, adc_channel_power;
    logic [1:0] attenuator_ramp_select, tdm_format_select;
    logic [1:0] speed_mode_select, clock_ratio_select, loopback_select;
    logic [1:0] adc_differential_enable;
    logic [3:0] dac_channel_power, zero_detect_mode_select;
    logic [3:0] dac_differential_enable;
    logic [2:0] audio_format_select, adc_output_format, overflow_mode_select;
    logic [63:0] attenuation_level;
    int mismatches = 0;
    int checked = 0;
    int n;

    codec_control_register_bank i_dut (.*);
    codec_host_model i_host (.*);

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    task automatic check(input string what, input logic [63:0] seen, exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic print_verdict();
        $display("mismatches %0d checked %0d", mismatches, checked);
        if (mismatches == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : print_verdict
    // Extra cycle so registered derived outputs have landed
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        i_host.write_reg(a, d);
        @(negedge clock);
    endtask : wr
    task automatic rd(input logic [4:0] a, input logic [7:0] e);
        i_host.read_reg(a, v);
        check("rd_data", v, e);
    endtask : rd
    // Counts output clock edges over eight system cycles
    task automatic toggles(input int exp);
        logic last;
        int t;
        t = 0;
        last = mclk_out;
        repeat (8) begin
            @(negedge clock);
            t += (mclk_out !== last);
            last = mclk_out;
        end
        check("mclk_toggles", t, exp);
    endtask : toggles

    // Stuck design cannot hang the run
    initial begin
        repeat (3000) @(posedge clock);
        mismatches++;
        print_verdict();
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        nrst = 1'b0;
        ce = 1'b1;
        power_down_pin_n = 1'b1;
        overflow_raw = 1'b0;
        zero_detect_raw = 2'b01;
        repeat (4) @(negedge clock);
        nrst = 1'b1;
        check("fmt", audio_format_select, 3'h4);
        check("ramp", attenuator_ramp_select, 2'h0);
        check("deemph", deemphasis_select, 8'h55);
        check("ovf_mode", overflow_mode_select, 3'h7);
        check("zd_mode", zero_detect_mode_select, 4'hf);
        rd(5'h03, 8'h80);
        i_host.power_up();
        @(negedge clock);
        check("pwr", {dac_group_power, adc_group_power}, 2'b11);
        check("zd", zero_detect_pins, 2'b01);
        check("trst", timing_reset_n, 1'b1);
        wr(5'h00, 8'h09);
        check("pwr", {dac_group_power, adc_group_power}, 2'b00);
        check("vref", reference_power, 1'b1);
        wr(5'h00, 8'h0e);
        check("zd", zero_detect_pins, 2'b11);
        check("trst", timing_reset_n, 1'b0);
        rd(5'h00, 8'h0e);
        wr(5'h00, 8'h0f);
        wr(5'h01, 8'h02);
        wr(5'h02, 8'h0a);
        check("adc_pwr", adc_channel_power, 2'b10);
        check("dac_pwr", dac_channel_power, 4'ha);
        wr(5'h08, 8'h01);
        wr(5'h09, 8'h06);
        check("adc_diff", adc_differential_enable, 2'b01);
        check("dac_diff", dac_differential_enable, 4'h6);
        // Output format remap for input modes 0 to 2 under ADC loopback
        for (n = 0; n < 3; n++) begin
            wr(5'h03, {n[2:0], 5'h01});
            wr(5'h06, 8'h17);
            check("mute", soft_mute_bit, 1'b1);
            check("afmt", adc_output_format, n == 2 ? 3'h5 : 3'h3);
        end
        for (n = 2; n < 4; n++) begin
            wr(5'h06, {2'b00, n[1:0], 4'h7});
            check("loop", {loop_adc_to_dac, loop_copy_input1},
                n == 2 ? 2'b01 : 2'b00);
        end
        wr(5'h03, 8'h18);
        check("mute", soft_mute_bit, 1'b0);
        check("tdm", tdm_format_select, 2'h3);
        // Enable low must freeze the bytes, so this write is lost
        ce = 1'b0;
        i_host.write_reg(5'h03, 8'h01);
        check("frozen", soft_mute_bit, 1'b0);
        ce = 1'b1;
        wr(5'h06, 8'h0f);
        overflow_raw = 1'b1;
        @(negedge clock);
        check("ovf_pin", zero_detect_pins[1], 1'b1);
        overflow_raw = 1'b0;
        @(negedge clock);
        check("ovf_pin", zero_detect_pins[1], 1'b0);
        wr(5'h04, 8'h0e);
        check("speed", speed_mode_select, 2'h0);
        wr(5'h04, 8'h0c);
        check("speed", {speed_mode_manual, speed_mode_select}, 3'h7);
        wr(5'h04, 8'h30);
        check("ratio", clock_ratio_select, 2'h3);
        toggles(0);
        wr(5'h04, 8'h40);
        toggles(8);
        wr(5'h04, 8'h41);
        toggles(4);
        for (n = 0; n < 8; n++)
            wr(5'h0a + n[4:0], 8'h11 * n[7:0]);
        // Unused range gets ones so any aliasing would show
        for (n = 19; n < 32; n++)
            i_host.write_reg(n[4:0], 8'hff);
        for (n = 0; n < 8; n++)
            check("att", attenuation_level[8*n +: 8], 8'h11 * n[7:0]);
        check("mute", soft_mute_bit, 1'b0);
        rd(5'h13, 8'h00);
        power_down_pin_n = 1'b0;
        repeat (2) @(negedge clock);
        power_down_pin_n = 1'b1;
        @(negedge clock);
        check("att", attenuation_level, {8{8'hff}});
        check("fmt", audio_format_select, 3'h4);
        rd(5'h04, 8'h00);
        print_verdict();
    end
endmodule : codec_control_register_bank_tb
